// ### mcr_pkg.sv
// Constants, types and shared decode for the message interrupt capability.
// Assumes a single user clock; byte offsets are config-space addresses.
package mcr_pkg;
   localparam int CFG_AW = 12;
   localparam logic [CFG_AW-1:0] OFS_CTRL = 12'h050;
   localparam logic [CFG_AW-1:0] OFS_ADDR_LO = 12'h054;
   localparam logic [CFG_AW-1:0] OFS_ADDR_HI = 12'h058;
   localparam logic [CFG_AW-1:0] OFS_DATA_32 = 12'h058;
   localparam logic [CFG_AW-1:0] OFS_DATA_64 = 12'h05c;
   localparam logic [CFG_AW-1:0] OFS_MASK_32 = 12'h05c;
   localparam logic [CFG_AW-1:0] OFS_MASK_64 = 12'h060;
   localparam logic [CFG_AW-1:0] OFS_PEND_32 = 12'h060;
   localparam logic [CFG_AW-1:0] OFS_PEND_64 = 12'h064;
   localparam logic [7:0] CAP_ID_MSI = 8'h05;
   localparam logic [7:0] NEXT_PTR_EXT = 8'h68;
   localparam logic [7:0] NEXT_PTR_PM = 8'h78;
   localparam int CTRL_PVM_BIT = 24;
   localparam int CTRL_A64_BIT = 23;
   localparam int CTRL_MME_LSB = 20;
   localparam int CTRL_MMC_LSB = 17;
   localparam int CTRL_EN_BIT = 16;
   localparam int CTRL_NXT_LSB = 8;
   localparam int CTRL_EN_BYTE = 2;
   localparam int ALIGN_BITS = 2;
   localparam int DATA_W = 16;
   localparam int MAX_VEC = 32;
   localparam int VEC_W = 5;
   localparam logic [2:0] CODE_MAX = 3'h5;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_CTRL = 3'b001,
      SEL_ADLO = 3'b010,
      SEL_ADHI = 3'b011,
      SEL_DATA = 3'b100,
      SEL_MASK = 3'b101,
      SEL_PEND = 3'b110
   } mcr_sel_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [CFG_AW-1:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } mcr_cfg_s;

   typedef struct packed {
      logic [63:0] addr;
      logic [31:0] data;
   } mcr_mwr_s;

   // Bits covered by a power-of-two vector count code
   function automatic logic [31:0] mcr_vec_mask(input logic [2:0] code);
      logic [31:0] m;
      m = 32'h0000_0000;
      unique case (code)
         3'h0: m = 32'h0000_0001;
         3'h1: m = 32'h0000_0003;
         3'h2: m = 32'h0000_000f;
         3'h3: m = 32'h0000_00ff;
         3'h4: m = 32'h0000_ffff;
         default: m = 32'hffff_ffff;
      endcase
      return m;
   endfunction
endpackage

// ### mcr_pend.sv
// Pending flag array, one flag per vector.
// Assumes set and clear come from logic on the same clock.
module mcr_pend
   import mcr_pkg::*;
#(
   parameter int NVEC = MAX_VEC
) (
   input wire logic clk_i,
   input wire logic rst_ni,
   input wire logic [NVEC-1:0] set_i,
   input wire logic [NVEC-1:0] clr_i,
   output logic [NVEC-1:0] pend_o
);
   if (NVEC < 1 || NVEC > MAX_VEC) begin : g_chk
      $error("NVEC out of range");
   end

   for (genvar i = 0; i < NVEC; i++) begin : g_flag
      // A set in the clearing cycle wins
      always_ff @(posedge clk_i) begin
         if (!rst_ni) begin
            pend_o[i] <= 1'b0;
         end else begin
            pend_o[i] <= set_i[i] | (pend_o[i] & ~clr_i[i]); // RULE19
         end
      end
   end
endmodule

// ### mcr_compose.sv
// Builds the interrupt payload from the data base value and vector number.
// Purely combinational; the caller registers the result.
module mcr_compose
   import mcr_pkg::*;
(
   input wire logic [DATA_W-1:0] base_i,
   input wire logic [2:0] code_i,
   input wire logic [VEC_W-1:0] vec_i,
   output logic [31:0] data_o
);
   logic [31:0] sub;
   logic [31:0] base_ext;

   assign base_ext = {{(32-DATA_W){1'b0}}, base_i};
   // Single vector gives an all-zero substitution field
   assign sub = (32'h0000_0001 << code_i) - 32'h0000_0001;
   assign data_o = (base_ext & ~sub) |
                   ({{(32-VEC_W){1'b0}}, vec_i} & sub); // RULE15
endmodule

// ### mcr_regs.sv
// Message signalled interrupt capability registers and interrupt issuer.
// Assumes config accesses and interrupt requests arrive on REF_CLK_I.
// Notes on behaviour
// RULE1 - Control bit 24 always reads one: per-vector masking is supported.
// RULE2 - Control bit 23 is a build-time flag for 64-bit address support.
// RULE3 - Enabled vector count field, writable, reset zero, codes 0..5 mean 1..32.
// RULE4 - Software must not enable more vectors than advertised as capable.
// RULE5 - Capable vector count field is read-only, fixed at build time.
// RULE6 - Global enable bit, reset zero; no interrupt is produced while clear.
// RULE7 - Next pointer reads the following capability offset, 0x68 or 0x78.
// RULE8 - Low byte of the control word reads capability identifier 0x05.
// RULE9 - Lower address bits 1:0 read zero, keeping word alignment.
// RULE10 - Lower address bits 31:2 are writable and reset to zero.
// RULE11 - With 64-bit support, upper and lower words form the write address.
// RULE12 - Without 64-bit support the upper address word reads zero.
// RULE13 - Data word offset depends on 64-bit support.
// RULE14 - Data base is 16 writable bits, reset zero; upper half reads zero.
// RULE15 - Low log2(N) payload bits carry the vector number; one vector unchanged.
// RULE16 - Mask word offset depends on 64-bit support.
// RULE17 - Only implemented mask bits are writable; the others read zero.
// RULE18 - A set mask bit blocks the message of its vector.
// RULE19 - One pending flag per vector, readable after the mask word.
// RULE20 - Enabled unmasked request sends one write; masked ones stay pending.
module mcr_regs
   import mcr_pkg::*;
#(
   parameter bit ADDR64 = 1'b1,
   parameter logic [2:0] CAP_CODE = 3'h5,
   parameter bit HAS_EXT_CAP = 1'b1
) (
   input wire logic REF_CLK_I,
   input wire logic RESETN_I,
   input wire mcr_cfg_s CFG_REQ_I,
   output logic [31:0] CFG_RDATA_O,
   output logic CFG_RVALID_O,
   input wire logic APP_MSI_REQ_I,
   input wire logic [VEC_W-1:0] APP_MSI_NUM_I,
   output logic MWR_VALID_O,
   input wire logic MWR_READY_I,
   output mcr_mwr_s MWR_O,
   output logic MSI_ENABLE_O,
   output logic [MAX_VEC-1:0] MSI_PENDING_O
);
   if (CAP_CODE > CODE_MAX) begin : g_chk
      $error("CAP_CODE beyond 32 vectors");
   end

   typedef enum logic {
      ISS_IDLE = 1'b0,
      ISS_SEND = 1'b1
   } mcr_iss_e;

   localparam logic [7:0] NEXT_PTR = HAS_EXT_CAP ? NEXT_PTR_EXT : NEXT_PTR_PM;
   localparam logic [31:0] IMPL_MASK = mcr_vec_mask(CAP_CODE);

   // Register selection shared by the read and write paths
   function automatic mcr_sel_e reg_sel(input logic [CFG_AW-1:0] a);
      mcr_sel_e s;
      s = SEL_NONE;
      if (a == OFS_CTRL) begin
         s = SEL_CTRL;
      end else if (a == OFS_ADDR_LO) begin
         s = SEL_ADLO;
      end else if (ADDR64) begin
         if (a == OFS_ADDR_HI) begin
            s = SEL_ADHI;
         end else if (a == OFS_DATA_64) begin
            s = SEL_DATA; // RULE13
         end else if (a == OFS_MASK_64) begin
            s = SEL_MASK; // RULE16
         end else if (a == OFS_PEND_64) begin
            s = SEL_PEND; // RULE19
         end
      end else begin
         if (a == OFS_DATA_32) begin
            s = SEL_DATA; // RULE13
         end else if (a == OFS_MASK_32) begin
            s = SEL_MASK; // RULE16
         end else if (a == OFS_PEND_32) begin
            s = SEL_PEND; // RULE19
         end
      end
      return s;
   endfunction

   // Byte-enable merge of a write into a stored word
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   mcr_sel_e wsel;
   mcr_sel_e rsel;
   mcr_sel_e rsel_q;
   logic [2:0] mme_q;
   logic en_q;
   logic [31:ALIGN_BITS] addr_lo_q;
   logic [31:0] addr_hi_q;
   logic [DATA_W-1:0] data_q;
   logic [31:0] mask_q;
   logic [31:0] ctrl_word;
   logic [31:0] lo_word;
   logic [31:0] merged;
   logic [31:0] data_mrg;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic rvalid_q;
   logic [31:0] pend;
   logic [31:0] pend_set;
   logic [31:0] pend_clr;
   logic [31:0] elig;
   logic pick_ok;
   logic [VEC_W-1:0] pick_idx;
   logic pick_masked;
   logic [31:0] composed;
   logic [63:0] full_addr;
   mcr_iss_e iss_q;
   logic [VEC_W-1:0] vec_q;
   mcr_mwr_s mwr_q;

   assign wsel = CFG_REQ_I.wr ? reg_sel(CFG_REQ_I.addr) : SEL_NONE;
   assign rsel = reg_sel(CFG_REQ_I.addr);

   // Control word fields
   always_comb begin
      ctrl_word = RST_WORD;
      ctrl_word[CTRL_PVM_BIT] = 1'b1; // RULE1
      ctrl_word[CTRL_A64_BIT] = ADDR64; // RULE2
      ctrl_word[CTRL_MME_LSB +: 3] = mme_q; // RULE3
      ctrl_word[CTRL_MMC_LSB +: 3] = CAP_CODE; // RULE5
      ctrl_word[CTRL_EN_BIT] = en_q; // RULE6
      ctrl_word[CTRL_NXT_LSB +: 8] = NEXT_PTR; // RULE7
      ctrl_word[7:0] = CAP_ID_MSI; // RULE8
   end

   assign lo_word = {addr_lo_q, {ALIGN_BITS{1'b0}}}; // RULE9

   // Vector count and global enable
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         mme_q <= 3'h0;
         en_q <= 1'b0;
      end else if (wsel == SEL_CTRL && CFG_REQ_I.be[CTRL_EN_BYTE]) begin
         mme_q <= CFG_REQ_I.wdata[CTRL_MME_LSB +: 3]; // RULE3
         en_q <= CFG_REQ_I.wdata[CTRL_EN_BIT]; // RULE6
      end
   end

   assign merged = be_merge(lo_word, CFG_REQ_I.wdata, CFG_REQ_I.be);
   assign data_mrg = be_merge({{(32-DATA_W){1'b0}}, data_q},
                              CFG_REQ_I.wdata, CFG_REQ_I.be);

   // Message address words
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         addr_lo_q <= '0;
      end else if (wsel == SEL_ADLO) begin
         addr_lo_q <= merged[31:ALIGN_BITS]; // RULE10
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         addr_hi_q <= RST_WORD;
      end else if (wsel == SEL_ADHI) begin
         addr_hi_q <= be_merge(addr_hi_q, CFG_REQ_I.wdata,
                               CFG_REQ_I.be); // RULE11
      end
   end

   // Data base value
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         data_q <= '0;
      end else if (wsel == SEL_DATA) begin
         data_q <= data_mrg[DATA_W-1:0]; // RULE14
      end
   end

   // Per-vector mask, only implemented bits stored
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         mask_q <= RST_WORD;
      end else if (wsel == SEL_MASK) begin
         mask_q <= be_merge(mask_q, CFG_REQ_I.wdata,
                            CFG_REQ_I.be) & IMPL_MASK; // RULE17
      end
   end

   // Read path, answer one cycle after the request
   always_comb begin
      rdata_d = RST_WORD;
      unique case (rsel)
         SEL_CTRL: rdata_d = ctrl_word;
         SEL_ADLO: rdata_d = lo_word; // RULE9
         SEL_ADHI: rdata_d = addr_hi_q;
         SEL_DATA: rdata_d = {{(32-DATA_W){1'b0}}, data_q}; // RULE14
         SEL_MASK: rdata_d = mask_q & IMPL_MASK; // RULE17
         SEL_PEND: rdata_d = pend & IMPL_MASK; // RULE19
         default: rdata_d = RST_WORD; // RULE12
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         rdata_q <= RST_WORD;
         rvalid_q <= 1'b0;
         rsel_q <= SEL_NONE;
      end else begin
         rvalid_q <= CFG_REQ_I.rd;
         rsel_q <= CFG_REQ_I.rd ? rsel : SEL_NONE;
         if (CFG_REQ_I.rd) begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign CFG_RDATA_O = rdata_q;
   assign CFG_RVALID_O = rvalid_q;

   // Requests for unimplemented vectors are dropped
   always_comb begin
      pend_set = RST_WORD;
      if (APP_MSI_REQ_I) begin
         pend_set[APP_MSI_NUM_I] = 1'b1;
      end
      pend_set = pend_set & IMPL_MASK;
   end

   always_comb begin
      pend_clr = RST_WORD;
      if (iss_q == ISS_SEND && MWR_READY_I) begin
         pend_clr[vec_q] = 1'b1;
      end
   end

   mcr_pend #(
      .NVEC(MAX_VEC)
   ) u_pend (
      .clk_i(REF_CLK_I),
      .rst_ni(RESETN_I),
      .set_i(pend_set),
      .clr_i(pend_clr),
      .pend_o(pend)
   );

   // Lowest eligible vector; masked or in-flight ones are skipped
   assign elig = pend & ~mask_q & IMPL_MASK &
                 ~((iss_q == ISS_SEND) ? pend_clr : RST_WORD); // RULE18
   always_comb begin
      pick_ok = 1'b0;
      pick_idx = '0;
      for (int i = MAX_VEC - 1; i >= 0; i--) begin
         if (elig[i]) begin
            pick_ok = 1'b1;
            pick_idx = VEC_W'(i);
         end
      end
   end
   assign pick_masked = mask_q[pick_idx];

   mcr_compose u_compose (
      .base_i(data_q),
      .code_i(mme_q),
      .vec_i(pick_idx),
      .data_o(composed)
   );

   assign full_addr = {ADDR64 ? addr_hi_q : RST_WORD, lo_word}; // RULE11

   // Issuer: one memory write per serviced pending flag
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         iss_q <= ISS_IDLE;
         vec_q <= '0;
         mwr_q <= '0;
      end else begin
         unique case (iss_q)
            ISS_IDLE: begin
               if (en_q && pick_ok) begin // RULE6
                  iss_q <= ISS_SEND; // RULE20
                  vec_q <= pick_idx;
                  mwr_q.addr <= full_addr;
                  mwr_q.data <= composed; // RULE15
               end
            end
            ISS_SEND: begin
               if (MWR_READY_I) begin
                  iss_q <= ISS_IDLE;
               end
            end
         endcase
      end
   end

   assign MWR_VALID_O = (iss_q == ISS_SEND);
   assign MWR_O = mwr_q;
   assign MSI_ENABLE_O = en_q;
   assign MSI_PENDING_O = pend;

   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RESETN_I);

   AST_PVM_ONE: assert property ( // RULE1
      CFG_RVALID_O && rsel_q == SEL_CTRL |-> CFG_RDATA_O[CTRL_PVM_BIT])
      else $error("masking capable bit read as zero");

   AST_CAP_ID: assert property ( // RULE8
      CFG_RVALID_O && rsel_q == SEL_CTRL |-> CFG_RDATA_O[7:0] == 8'h05)
      else $error("capability identifier wrong");

   AST_NEXT_PTR: assert property ( // RULE7
      CFG_RVALID_O && rsel_q == SEL_CTRL
      |-> CFG_RDATA_O[15:8] == 8'h68 || CFG_RDATA_O[15:8] == 8'h78)
      else $error("next pointer wrong");

   AST_MME_WRITE: assert property ( // RULE3
      CFG_REQ_I.wr && CFG_REQ_I.addr == OFS_CTRL && CFG_REQ_I.be[2]
      |=> mme_q == $past(CFG_REQ_I.wdata[22:20]))
      else $error("vector count write lost");

   AST_NO_SEND_DISABLED: assert property ( // RULE6
      $rose(MWR_VALID_O) |-> $past(en_q))
      else $error("write issued while disabled");

   AST_ADDR_ALIGN: assert property ( // RULE9
      MWR_VALID_O |-> MWR_O.addr[1:0] == 2'b00)
      else $error("interrupt address not word aligned");

   AST_UPPER_ZERO: assert property ( // RULE12
      MWR_VALID_O && !ADDR64 |-> MWR_O.addr[63:32] == 32'h0000_0000)
      else $error("upper address nonzero without 64-bit support");

   AST_MASK_BLOCKS: assert property ( // RULE18
      $rose(MWR_VALID_O) |-> !$past(pick_masked))
      else $error("masked vector was sent");

   AST_MASK_UNIMPL: assert property ( // RULE17
      CFG_RVALID_O && rsel_q == SEL_MASK |-> (CFG_RDATA_O & ~IMPL_MASK) == 0)
      else $error("unimplemented mask bit reads one");

   AST_DATA_HIGH: assert property ( // RULE14
      MWR_VALID_O |-> MWR_O.data[31:16] == 16'h0000)
      else $error("payload upper half nonzero");

   AST_SEND_HOLD: assert property ( // RULE20
      MWR_VALID_O && !MWR_READY_I |=> MWR_VALID_O && $stable(MWR_O))
      else $error("write dropped before acceptance");

   AST_PEND_SET: assert property ( // RULE19
      APP_MSI_REQ_I && IMPL_MASK[APP_MSI_NUM_I] |=> pend[$past(APP_MSI_NUM_I)])
      else $error("request did not set pending flag");
endmodule

// ### mcr_rp_model.sv
// Root port memory model: takes interrupt writes after a set stall.
// Assumes the offer stays up, unchanged, until ready is seen high.
module mcr_rp_model
   import mcr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_ni,
   input wire logic valid_i,
   input wire mcr_mwr_s mwr_i,
   input wire logic [3:0] stall_i,
   output logic ready_o,
   output int n_acc_o,
   output mcr_mwr_s got_o
);
   logic [3:0] wait_q;

   // Ready only answers an offer, after stall_i cycles of waiting
   assign ready_o = valid_i && (wait_q >= stall_i);

   always_ff @(posedge clk_i) begin
      if (!rst_ni) begin
         wait_q <= 4'h0;
         n_acc_o <= 0;
         got_o <= '0;
      end else if (ready_o) begin
         wait_q <= 4'h0;
         n_acc_o <= n_acc_o + 1;
         got_o <= mwr_i;
      end else if (valid_i) begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule

// ### testbench.sv
// Self-checking bench for the message interrupt capability registers.
// Assumes one 40 MHz clock; a second instance covers 32-bit addressing.
module testbench import mcr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic rst_n;
   mcr_cfg_s req [2];
   logic [31:0] rdata [2];
   logic rvalid [2];
   logic app_req;
   logic [VEC_W-1:0] app_num;
   logic mwr_valid;
   logic mwr_ready;
   mcr_mwr_s mwr;
   logic msi_en;
   logic [MAX_VEC-1:0] pend;
   logic mwr_valid_b;
   mcr_mwr_s mwr_b;
   logic [MAX_VEC-1:0] pend_b;
   logic [3:0] stall;
   int n_acc;
   mcr_mwr_s got;
   logic [63:0] addr_exp;
   int seen;
   int err_total;
   int checked;

   mcr_regs dut (.REF_CLK_I(clk), .RESETN_I(rst_n), .CFG_REQ_I(req[0]),
      .CFG_RDATA_O(rdata[0]), .CFG_RVALID_O(rvalid[0]),
      .APP_MSI_REQ_I(app_req), .APP_MSI_NUM_I(app_num),
      .MWR_VALID_O(mwr_valid), .MWR_READY_I(mwr_ready), .MWR_O(mwr),
      .MSI_ENABLE_O(msi_en), .MSI_PENDING_O(pend));
   // 32-bit addressing, two capable vectors, power management next
   mcr_regs #(.ADDR64(1'b0), .CAP_CODE(3'h1), .HAS_EXT_CAP(1'b0)) dut_b (
      .REF_CLK_I(clk), .RESETN_I(rst_n), .CFG_REQ_I(req[1]),
      .CFG_RDATA_O(rdata[1]), .CFG_RVALID_O(rvalid[1]),
      .APP_MSI_REQ_I(app_req), .APP_MSI_NUM_I(app_num),
      .MWR_VALID_O(mwr_valid_b),
      .MWR_READY_I(1'b1), .MWR_O(mwr_b), .MSI_ENABLE_O(),
      .MSI_PENDING_O(pend_b));
   mcr_rp_model rp (.clk_i(clk), .rst_ni(rst_n), .valid_i(mwr_valid),
      .mwr_i(mwr), .stall_i(stall), .ready_o(mwr_ready),
      .n_acc_o(n_acc), .got_o(got));

   task automatic end_sim();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got_v, input logic [63:0] exp_v);
      checked++;
      if (got_v !== exp_v) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got_v, exp_v);
      end
   endtask

   task automatic cfg_wr(input int u, input logic [11:0] a,
                         input logic [31:0] d, input logic [3:0] be);
      @(posedge clk);
      req[u] <= '{1'b1, 1'b0, a, d, be};
      @(posedge clk);
      req[u].wr <= 1'b0;
   endtask

   task automatic cfg_rd(input int u, input logic [11:0] a,
                         input logic [31:0] e);
      @(posedge clk);
      req[u] <= '{1'b0, 1'b1, a, 32'h0, 4'h0};
      @(posedge clk);
      req[u].rd <= 1'b0;
      #1;
      chk(64'(rvalid[u]), 64'h1);
      chk(64'(rdata[u]), 64'(e));
   endtask

   task automatic irq(input logic [4:0] v);
      @(posedge clk);
      app_req <= 1'b1;
      app_num <= v;
      @(posedge clk);
      app_req <= 1'b0;
   endtask

   // Waits, bounded, for the next accepted write and judges it
   task automatic wait_mwr(input logic [31:0] d);
      int k;
      k = 0;
      while (n_acc == seen && k < 40) begin
         @(posedge clk);
         k++;
      end
      #1;
      chk(64'(n_acc), 64'(seen + 1));
      chk(got.addr, addr_exp);
      chk(64'(got.data), 64'(d));
      seen = n_acc;
   endtask

   task automatic no_mwr();
      repeat (12) @(posedge clk);
      #1;
      chk(64'(n_acc), 64'(seen));
      chk(64'(mwr_valid), 64'h0);
   endtask

   task automatic t_reset();
      logic [11:0] ofs [6];
      ofs = '{OFS_ADDR_LO, OFS_ADDR_HI, OFS_DATA_64, OFS_MASK_64,
              OFS_PEND_64, 12'h100};
      cfg_rd(0, OFS_CTRL, 32'h018a_6805);
      foreach (ofs[i]) cfg_rd(0, ofs[i], 32'h0);
      chk(64'(msi_en), 64'h0);
   endtask

   task automatic t_regs();
      cfg_wr(0, OFS_ADDR_LO, 32'hffff_ffff, 4'hf);
      cfg_rd(0, OFS_ADDR_LO, 32'hffff_fffc);
      cfg_wr(0, OFS_ADDR_HI, 32'h89ab_cdef, 4'hf);
      cfg_rd(0, OFS_ADDR_HI, 32'h89ab_cdef);
      cfg_wr(0, OFS_DATA_64, 32'hffff_abcd, 4'hf);
      cfg_rd(0, OFS_DATA_64, 32'h0000_abcd);
      cfg_wr(0, OFS_MASK_64, 32'h8000_0001, 4'hf);
      cfg_rd(0, OFS_MASK_64, 32'h8000_0001);
      cfg_wr(0, OFS_MASK_64, 32'h0, 4'hf);
   endtask

   task automatic t_disabled();
      irq(5'h03);
      no_mwr();
      chk(64'(pend), 64'h8);
      cfg_rd(0, OFS_PEND_64, 32'h0000_0008);
   endtask

   task automatic t_codes();
      logic [31:0] m;
      for (int c = 0; c < 6; c++) begin
         m = (32'h1 << c) - 32'h1;
         cfg_wr(0, OFS_CTRL, 32'(c) << 20 | 32'h1_0000, 4'h4);
         if (c == 0) wait_mwr(32'h0000_abcd);
         cfg_rd(0, OFS_CTRL, 32'h018b_6805 | 32'(c) << 20);
         chk(64'(msi_en), 64'h1);
         irq(5'h1f);
         wait_mwr(32'habcd & ~m | 32'h1f & m);
      end
      chk(64'(pend), 64'h0);
   endtask

   task automatic t_order();
      stall <= 4'h3;
      cfg_wr(0, OFS_MASK_64, 32'h0000_0284, 4'hf);
      irq(5'h09);
      irq(5'h07);
      irq(5'h02);
      no_mwr();
      cfg_rd(0, OFS_PEND_64, 32'h0000_0284);
      cfg_wr(0, OFS_MASK_64, 32'h0000_0280, 4'hf);
      wait_mwr(32'h0000_abc2);
      cfg_wr(0, OFS_MASK_64, 32'h0, 4'hf);
      wait_mwr(32'h0000_abc7);
      wait_mwr(32'h0000_abc9);
   endtask

   task automatic t_disable();
      cfg_wr(0, OFS_CTRL, 32'h0050_0000, 4'h4);
      cfg_wr(0, OFS_CTRL, 32'h0051_0000, 4'h3);
      cfg_rd(0, OFS_CTRL, 32'h01da_6805);
      irq(5'h04);
      no_mwr();
      chk(64'(pend), 64'h10);
   endtask

   task automatic t_narrow();
      int k;
      cfg_rd(1, OFS_CTRL, 32'h0102_7805);
      cfg_wr(1, OFS_DATA_32, 32'hffff_1234, 4'hf);
      cfg_rd(1, OFS_DATA_32, 32'h0000_1234);
      cfg_wr(1, OFS_MASK_32, 32'hffff_ffff, 4'hf);
      cfg_rd(1, OFS_MASK_32, 32'h0000_0003);
      cfg_rd(1, OFS_PEND_32, 32'h0);
      cfg_rd(1, OFS_PEND_64, 32'h0);
      // Earlier requests all named vectors above this instance's two
      chk(64'(pend_b), 64'h0);
      cfg_wr(1, OFS_ADDR_LO, 32'h1234_567b, 4'hf);
      cfg_wr(1, OFS_MASK_32, 32'h0, 4'hf);
      cfg_wr(1, OFS_CTRL, 32'h0001_0000, 4'h4);
      irq(5'h01);
      k = 0;
      while (mwr_valid_b !== 1'b1 && k < 20) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk(64'(mwr_valid_b), 64'h1);
      chk(mwr_b.addr, 64'h0000_0000_1234_5678);
      chk(64'(mwr_b.data), 64'h0000_1234);
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      rst_n = 1'b0;
      req[0] = '0;
      req[1] = '0;
      app_req = 1'b0;
      app_num = '0;
      stall = 4'h2;
      seen = 0;
      err_total = 0;
      checked = 0;
      addr_exp = 64'h89ab_cdef_ffff_fffc;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_disabled();
      t_codes();
      t_order();
      t_disable();
      t_narrow();
      end_sim();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      end_sim();
   end
endmodule
